// >>> rtl/dis_flag_bank.sv
module dis_flag_bank #(
  parameter int N = dis_pkg::NCH
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Events and clears, one bit per channel
  input  wire logic [N-1:0] setPulse,
  input  wire logic [N-1:0] clrPulse,
  input  wire logic [N-1:0] ovrClr,
  // Sticky state
  output logic      [N-1:0] flag,
  output logic      [N-1:0] overrun
);

  // -----------------------------------------------------------------
  // Per-channel sticky flags
  // -----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_ch
    // A new event beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        flag[i] <= 1'b0;
      end else if (setPulse[i]) begin
        flag[i] <= 1'b1;
      end else if (clrPulse[i]) begin
        flag[i] <= 1'b0;
      end
    end

    // Event landing on an unserviced flag; only a W1C write drops it
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        overrun[i] <= 1'b0;
      end else if (setPulse[i] && flag[i] && !clrPulse[i]) begin
        overrun[i] <= 1'b1;
      end else if (ovrClr[i]) begin
        overrun[i] <= 1'b0;
      end
    end
  end

endmodule

// >>> rtl/dis_irq_status_clear.sv
// Function
// - Read-only per-channel done status, post-enable.
// - Done status ch1 bit1, ch0 bit0, reset 0.
// - Writing one clears channel's done status.
// - Zero writes ignored; done clear is write-only.
// - Read-only per-channel fault status, post-enable.
// - Fault status ch0 bit0, ch1 bit1.
// - Writing one clears channel's fault status.
// - Zero writes ignored; fault clear is write-only.
// - Raw flags kept before enables; status derived.
// - Channel interrupt on done or fault, enabled.
module dis_irq_status_clear (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [dis_pkg::SW-1:0]      wb_sel_i,
  input  wire logic [dis_pkg::AW-1:0]      wb_adr_i,
  input  wire logic [dis_pkg::DW-1:0]      wb_dat_i,
  output logic      [dis_pkg::DW-1:0]      wb_dat_o,
  output logic                             wb_ack_o,
  // Transfer engine side
  input  wire dis_pkg::dis_chan_t          rawEvt,
  input  wire dis_pkg::dis_chan_t          chEnable,
  // Interrupt outputs
  output logic      [dis_pkg::NCH-1:0]     chanIrq,
  output logic                             irqOut
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  dis_pkg::dis_bus_state_t busState;
  dis_pkg::dis_chan_t      rawFlag;
  dis_pkg::dis_chan_t      postFlag;
  dis_pkg::dis_chan_t      clrReq;
  dis_pkg::dis_chan_t      ovrFlag;
  dis_pkg::dis_chan_t      ovrClrReq;

  logic                        busTake;
  logic                        wrTake;
  logic [dis_pkg::DW-1:0]      rdWord;
  logic [dis_pkg::NCH-1:0]     combined;
  logic [dis_pkg::NCH-1:0]     mask_reg;
  logic [dis_pkg::NCH-1:0]     wrBits;

  logic ch0_done_irq_flag;
  logic ch1_done_irq_flag;
  logic ch0_fault_irq_flag;
  logic ch1_fault_irq_flag;
  logic ch0_done_raw_flag;
  logic ch1_done_raw_flag;
  logic ch0_fault_raw_flag;
  logic ch1_fault_raw_flag;
  logic ch0_done_irq_clr;
  logic ch1_done_irq_clr;
  logic ch0_fault_irq_clr;
  logic ch1_fault_irq_clr;

  // -----------------------------------------------------------------
  // Bus handshake
  // -----------------------------------------------------------------
  // One wait state: take the request, ack in the next cycle, then drop
  // ack for one idle cycle; a master that still holds stb is taken again.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busState <= dis_pkg::BUS_IDLE;
    end else begin
      case (busState)
        dis_pkg::BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            busState <= dis_pkg::BUS_ACK;
          end
        end
        dis_pkg::BUS_ACK: begin
          busState <= dis_pkg::BUS_IDLE;
        end
        default: begin
          busState <= dis_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign busTake  = wb_cyc_i && wb_stb_i && (busState == dis_pkg::BUS_IDLE);
  assign wb_ack_o = (busState == dis_pkg::BUS_ACK);

  // Only lane 0 carries defined bits; other lanes are don't-care.
  assign wrTake = busTake && wb_we_i && wb_sel_i[dis_pkg::LANE0];
  assign wrBits = wb_dat_i[dis_pkg::NCH-1:0];

  // -----------------------------------------------------------------
  // Clear decode
  // -----------------------------------------------------------------
  // A clear is a one-cycle pulse per written one; zeros do nothing.
  always_comb begin
    clrReq    = '0;
    ovrClrReq = '0;
    if (wrTake) begin
      if (wb_adr_i == dis_pkg::OFS_DONE_CLEAR) begin
        clrReq.done = wrBits;
      end else if (wb_adr_i == dis_pkg::OFS_FAULT_CLEAR) begin
        clrReq.fault = wrBits;
      end else if (wb_adr_i == dis_pkg::OFS_OVERRUN) begin
        ovrClrReq.done  = wb_dat_i[dis_pkg::OVR_DONE_LSB +: dis_pkg::NCH];
        ovrClrReq.fault = wb_dat_i[dis_pkg::OVR_FAULT_LSB +: dis_pkg::NCH];
      end
    end
  end

  assign ch0_done_irq_clr  = clrReq.done[0];
  assign ch1_done_irq_clr  = clrReq.done[1];
  assign ch0_fault_irq_clr = clrReq.fault[0];
  assign ch1_fault_irq_clr = clrReq.fault[1];

  // -----------------------------------------------------------------
  // Raw flags
  // -----------------------------------------------------------------
  // The clear acts on the raw flag, so a cleared channel stays clear
  // even if software later turns its enable back on.
  dis_flag_bank #(
    .N (dis_pkg::NCH)
  ) u_done_bank (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .setPulse (rawEvt.done),
    .clrPulse (clrReq.done),
    .ovrClr   (ovrClrReq.done),
    .flag     (rawFlag.done),
    .overrun  (ovrFlag.done)
  );

  dis_flag_bank #(
    .N (dis_pkg::NCH)
  ) u_fault_bank (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .setPulse (rawEvt.fault),
    .clrPulse (clrReq.fault),
    .ovrClr   (ovrClrReq.fault),
    .flag     (rawFlag.fault),
    .overrun  (ovrFlag.fault)
  );

  assign ch0_done_raw_flag  = rawFlag.done[0];
  assign ch1_done_raw_flag  = rawFlag.done[1];
  assign ch0_fault_raw_flag = rawFlag.fault[0];
  assign ch1_fault_raw_flag = rawFlag.fault[1];

  // -----------------------------------------------------------------
  // Post-enable status
  // -----------------------------------------------------------------
  // Enables gate the view only; the raw event is remembered regardless.
  assign postFlag.done  = rawFlag.done & chEnable.done;
  assign postFlag.fault = rawFlag.fault & chEnable.fault;

  assign ch0_done_irq_flag  = postFlag.done[0];
  assign ch1_done_irq_flag  = postFlag.done[1];
  assign ch0_fault_irq_flag = postFlag.fault[0];
  assign ch1_fault_irq_flag = postFlag.fault[1];

  assign combined = postFlag.done | postFlag.fault;

  // -----------------------------------------------------------------
  // Interrupt mask and outputs
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_reg <= dis_pkg::MASK_RST;
    end else if (wrTake && wb_adr_i == dis_pkg::OFS_IRQ_MASK) begin
      mask_reg <= wrBits;
    end
  end

  // Registered so the line is glitch free toward the interrupt fabric.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chanIrq <= dis_pkg::FLAG_RST;
    end else begin
      chanIrq <= combined;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(combined & mask_reg);
    end
  end

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  // Clear registers are write-only and read as zero, as do holes.
  always_comb begin
    rdWord = '0;
    if (wb_adr_i == dis_pkg::OFS_COMBINED) begin
      rdWord[dis_pkg::NCH-1:0] = combined;
    end else if (wb_adr_i == dis_pkg::OFS_DONE_STATUS) begin
      rdWord[0] = ch0_done_irq_flag;
      rdWord[1] = ch1_done_irq_flag;
    end else if (wb_adr_i == dis_pkg::OFS_FAULT_STATUS) begin
      rdWord[0] = ch0_fault_irq_flag;
      rdWord[1] = ch1_fault_irq_flag;
    end else if (wb_adr_i == dis_pkg::OFS_DONE_RAW) begin
      rdWord[0] = ch0_done_raw_flag;
      rdWord[1] = ch1_done_raw_flag;
    end else if (wb_adr_i == dis_pkg::OFS_FAULT_RAW) begin
      rdWord[0] = ch0_fault_raw_flag;
      rdWord[1] = ch1_fault_raw_flag;
    end else if (wb_adr_i == dis_pkg::OFS_IRQ_MASK) begin
      rdWord[dis_pkg::NCH-1:0] = mask_reg;
    end else if (wb_adr_i == dis_pkg::OFS_OVERRUN) begin
      rdWord[dis_pkg::OVR_DONE_LSB +: dis_pkg::NCH]  = ovrFlag.done;
      rdWord[dis_pkg::OVR_FAULT_LSB +: dis_pkg::NCH] = ovrFlag.fault;
    end else if (wb_adr_i == dis_pkg::OFS_DONE_CLEAR) begin
      rdWord = '0;
    end else if (wb_adr_i == dis_pkg::OFS_FAULT_CLEAR) begin
      rdWord = '0;
    end
  end

  // Data is sampled at the take edge and held through the ack cycle.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_dat_o <= dis_pkg::DAT_RST;
    end else if (busTake && !wb_we_i) begin
      wb_dat_o <= rdWord;
    end
  end

endmodule

// >>> rtl/dis_pkg.sv
package dis_pkg;

  // -----------------------------------------------------------------
  // Sizes
  // -----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int DW  = 32;
  localparam int AW  = 8;
  localparam int SW  = 4;

  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_COMBINED     = 8'h00;
  localparam logic [AW-1:0] OFS_DONE_STATUS  = 8'h04;
  localparam logic [AW-1:0] OFS_DONE_CLEAR   = 8'h08;
  localparam logic [AW-1:0] OFS_FAULT_STATUS = 8'h0c;
  localparam logic [AW-1:0] OFS_FAULT_CLEAR  = 8'h10;
  localparam logic [AW-1:0] OFS_DONE_RAW     = 8'h14;
  localparam logic [AW-1:0] OFS_FAULT_RAW    = 8'h18;
  localparam logic [AW-1:0] OFS_IRQ_MASK     = 8'h40;
  localparam logic [AW-1:0] OFS_OVERRUN      = 8'h44;

  // -----------------------------------------------------------------
  // Field positions and reset values
  // -----------------------------------------------------------------
  localparam int OVR_DONE_LSB  = 0;
  localparam int OVR_FAULT_LSB = 2;
  localparam int ADR_WORD_LSB  = 2;
  localparam int LANE0         = 0;

  localparam logic [NCH-1:0] FLAG_RST = 2'h0;
  localparam logic [NCH-1:0] MASK_RST = 2'h0;
  localparam logic [DW-1:0]  DAT_RST  = 32'h0000_0000;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0] done;
    logic [NCH-1:0] fault;
  } dis_chan_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } dis_bus_state_t;

endpackage

// >>> test/dis_engine_model.sv
module dis_engine_model (
  // Clock
  input  wire logic         ref_clk,
  // Requests from the bench
  input  wire dis_pkg::dis_chan_t evtReq,
  input  wire dis_pkg::dis_chan_t enReq,
  // Transfer engine outputs
  output dis_pkg::dis_chan_t      rawEvt,
  output dis_pkg::dis_chan_t      chEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Engine outputs change only after an edge, like real flops
  // ---------------------------------------------------------------
  initial begin
    rawEvt = '0;
    chEnable = '0;
  end
  always @(posedge ref_clk) begin
    rawEvt <= evtReq;
    chEnable <= enReq;
  end
endmodule

// >>> test/dis_irq_status_clear_props.sv
module dis_irq_status_clear_props (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  // Bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [dis_pkg::SW-1:0] wb_sel_i,
  input wire logic [dis_pkg::AW-1:0] wb_adr_i,
  input wire logic [dis_pkg::DW-1:0] wb_dat_i,
  input wire logic [dis_pkg::DW-1:0] wb_dat_o,
  input wire logic                   wb_ack_o,
  // Engine and interrupts
  input wire dis_pkg::dis_chan_t     rawEvt,
  input wire dis_pkg::dis_chan_t     chEnable,
  input wire logic [dis_pkg::NCH-1:0] chanIrq,
  input wire logic                   irqOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  AST_ACK_LAT: assert property (req |=> wb_ack_o) else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_EVT_IRQ: assert property (rawEvt.done[0] && chEnable.done[0] ##1 chEnable.done[0]
    |=> chanIrq[0]) else $error("done event lost");
  AST_EN_GATE: assert property (chanIrq[1]
    |-> $past(chEnable.done[1] || chEnable.fault[1])) else $error("irq without enable");
  AST_DONE_CLR: assert property ((wr && wb_adr_i == dis_pkg::OFS_DONE_CLEAR && wb_dat_i[0]
    && !rawEvt.done[0]) ##1 !chEnable.fault[0] |=> !chanIrq[0]) else $error("clear failed");
  AST_SET_WINS: assert property ((wr && wb_adr_i == dis_pkg::OFS_FAULT_CLEAR && wb_dat_i[1]
    && rawEvt.fault[1] && chEnable.fault[1]) ##1 chEnable.fault[1] |=> chanIrq[1])
    else $error("event lost to clear");
  AST_WO_READ: assert property ((req && !wb_we_i && (wb_adr_i == dis_pkg::OFS_DONE_CLEAR
    || wb_adr_i == dis_pkg::OFS_FAULT_CLEAR)) |=> wb_dat_o == '0) else $error("clear reg readable");
  AST_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:4] == 28'h0) else $error("upper bits set");
endmodule

bind dis_irq_status_clear dis_irq_status_clear_props u_props (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rawEvt(rawEvt), .chEnable(chEnable), .chanIrq(chanIrq), .irqOut(irqOut));

// >>> test/dis_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               ref_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               wbCyc = 1'b0;
  logic               wbStb = 1'b0;
  logic               wbWe = 1'b0;
  logic [7:0]         wbAdr = '0;
  logic [31:0]        wbDatI = '0;
  logic [31:0]        wbDatO, rd;
  logic               wbAck, irqOut;
  logic [1:0]         chanIrq, maskM;
  dis_pkg::dis_chan_t evtReq = '0;
  dis_pkg::dis_chan_t enReq = '0;
  dis_pkg::dis_chan_t rawEvt, chEnable, rawM, enM, ovrM;
  int                 n_fail = 0;
  int                 comparisons = 0;
  int                 seed = 32'h8b42;
  int                 cycles = 0;
  localparam logic [7:0] ADRS [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                                       8'h40, 8'h3c, 8'h44};
  localparam logic [7:0] WADR [8] = '{8'h08, 8'h10, 8'h40, 8'h04, 8'h44, 8'h08, 8'h10,
                                      8'h14};
  // Corner cases first: set beats clear, overrun set, overrun cleared, set beats overrun clear
  localparam logic [31:0] CORNER [4] = '{32'h0000_18ff, 32'h0000_19ff, 32'h0000_7cf0,
                                         32'h0000_7cff};

  dis_engine_model u_dis_engine_model (.ref_clk(ref_clk), .evtReq(evtReq), .enReq(enReq),
    .rawEvt(rawEvt), .chEnable(chEnable));
  dis_irq_status_clear u_dis_irq_status_clear (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_sel_i(4'hf), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .rawEvt(rawEvt),
    .chEnable(chEnable), .chanIrq(chanIrq), .irqOut(irqOut));

  initial forever #25 ref_clk = ~ref_clk;
  // Generous ceiling: the run needs about 5200 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge ref_clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] expv(input logic [7:0] a);
    case (a)
      8'h00: expv = {30'h0, (rawM.done & enM.done) | (rawM.fault & enM.fault)};
      8'h04: expv = {30'h0, rawM.done & enM.done};
      8'h0c: expv = {30'h0, rawM.fault & enM.fault};
      8'h14: expv = {30'h0, rawM.done};
      8'h18: expv = {30'h0, rawM.fault};
      8'h40: expv = {30'h0, maskM};
      8'h44: expv = {28'h0, ovrM.fault, ovrM.done};
      default: expv = 32'h0;
    endcase
  endfunction

  task automatic chkAll();
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, ADRS[i], 32'h0);
      chk(rd, expv(ADRS[i]));
    end
    chk({30'h0, chanIrq}, expv(8'h00));
    chk({31'h0, irqOut}, {31'h0, |(expv(8'h00) & {30'h0, maskM})});
  endtask

  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  oc;
    dis_pkg::dis_chan_t ev;
    dis_pkg::dis_chan_t clrM;
    rawM = '0;
    enM = '0;
    ovrM = '0;
    maskM = 2'h0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chkAll();
    for (int k = 0; k < 150; k++) begin
      r = (k < 4) ? CORNER[k] : $random(seed);
      ev = r[3:0];
      enM = r[7:4];
      evtReq <= ev;
      enReq <= enM;
      @(posedge ref_clk);
      evtReq <= '0;
      a = WADR[r[10:8]];
      d = (a == 8'h44) ? {28'h0, r[14:11]} : {30'h0, r[12:11]};
      // Event lands on the same edge that takes the write
      wb(1'b1, a, d);
      clrM = '0;
      if (a == 8'h08) clrM.done = d[1:0];
      if (a == 8'h10) clrM.fault = d[1:0];
      oc = (a == 8'h44) ? {d[1:0], d[3:2]} : 4'h0;
      if (a == 8'h40) maskM = d[1:0];
      // Overrun: event on an already set flag that is not being cleared
      ovrM = (ovrM & ~oc) | (ev & rawM & ~clrM);
      rawM = (rawM & ~clrM) | ev;
      chkAll();
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rawM = '0;
    ovrM = '0;
    maskM = 2'h0;
    chkAll();
    results();
  end
endmodule
